// ==== logic/stp_map.vh ====
/*
 Holds the character codes, limits and option encodings used by the
 terminal line parser; its transmit queue does not include them. Assumes plain byte
 framing from a serial receiver.
*/
`ifndef STP_MAP_VH
`define STP_MAP_VH

`define STP_CH_NUL 8'h00
`define STP_CH_BS 8'h08
`define STP_CH_LF 8'h0A
`define STP_CH_CR 8'h0D
`define STP_CH_ESC 8'h1B
`define STP_CH_SP 8'h20
`define STP_CH_LBR 8'h5B
`define STP_CH_BSL 8'h5C
`define STP_CH_RBR 8'h5D
`define STP_CH_DEL 8'h7F
`define STP_CH_S 8'h53
`define STP_CH_Y 8'h59
`define STP_PRINT_LO 8'h20
`define STP_PRINT_HI 8'h7E

`define STP_MAX_LEN 122

`define STP_ONL_NONE 3'h0
`define STP_ONL_CRLF 3'h1
`define STP_ONL_NUL 3'h2
`define STP_ONL_CR 3'h3
`define STP_ONL_LFCR 3'h4
`define STP_ONL_LF 3'h5

`define STP_SWID 8'h47
`define STP_RC_LUN 2'h0
`define STP_BRIDGE_NONE 2'h0

`endif

// ==== logic/stp_parser.v ====
/*
 Character front end of a serial terminal mode: frames bracketed lines,
 edits, echoes and handshakes, and hands finished lines out as bytes.
 Assumes a byte receiver and transmitter on the same clock; the option
 inputs are static configuration levels from the controller.
*/
// Notes on behaviour
// - handshake string after each accepted message
// - erase key sends configured erase response
// - erase only with line editing, else illegal
// - input terminator NUL or CR by option
// - six selectable output newline sequences
// - only limited commands before session; not gated here, left to the command layer
// - drop everything before left bracket
// - text case-sensitive, hex digits any case
// - message at most 122 chars with brackets
// - only printable characters inside a message
// - escape drops line, maybe outputs newline
// - erase removes last buffered character
// - backslash then newline continues the line
// - illegal character clears line, hunt start
// - hex pairs, optional single space between; code skips any number of spaces between pairs
// - implied software id 47h, unit 00b
// - request byte layout, even function
// - response layout with completion code
// - text commands start with SYS
// - bridge field selects bridged tracking
// - echo every received character when enabled; erase keys that edit a line are not echoed
`timescale 1ns/1ps
`default_nettype none
`include "stp_map.vh"

module stp_parser #(
   parameter MAXLEN = `STP_MAX_LEN,
   parameter QDEPTH = 16
)(
   input wire mclk,
   input wire rst_n,
   input wire [7:0] rx_data,
   input wire rx_valid,
   output wire rx_ready,
   output wire [7:0] tx_data,
   output wire tx_valid,
   input wire tx_ready,
   input wire cfg_edit_en,
   input wire cfg_echo_en,
   input wire cfg_hshk_en,
   input wire cfg_erase_bksp,
   input wire cfg_inl_cr,
   input wire [2:0] cfg_onl_sel,
   input wire session_up,
   input wire ready_more,
   output reg [7:0] msg_byte,
   output reg msg_byte_valid,
   output reg msg_done,
   output reg msg_is_text,
   output reg msg_is_bridged,
   output reg msg_error,
   output wire [7:0] msg_swid,
   output wire [1:0] msg_lun,
   output reg [6:0] msg_len
);
   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   reg rs1_reg;
   reg rs2_reg;
   wire rst_sn;
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
      end
      else
      begin
         rs1_reg <= 1'b1;
         rs2_reg <= rs1_reg;
      end
   end
   assign rst_sn = rs2_reg;

   // ---------------------------------------------------------------
   // states and line buffer
   // ---------------------------------------------------------------
   localparam S_HUNT = 2'h0;
   localparam S_BODY = 2'h1;
   localparam S_CONT = 2'h2;
   localparam S_ESC = 2'h3;

   reg [1:0] st_reg;
   reg [1:0] st_next;
   reg [7:0] buf_reg [0:MAXLEN-1];
   reg [6:0] len_reg;
   reg [6:0] len_next;
   reg hs_pend_reg;
   reg out_busy_reg;
   reg [6:0] out_idx_reg;
   wire q_space;
   reg q_push;
   reg [7:0] q_data;
   reg [2:0] emit_reg;
   reg [2:0] emit_len_reg;
   reg [7:0] emit_buf_reg [0:6];

   assign msg_swid = `STP_SWID;
   assign msg_lun = `STP_RC_LUN;

   // one byte per strobe, only when queue has at least four free entries
   // closed in reset and while a handshake is being loaded
   assign rx_ready = rst_sn && q_space && (emit_reg == emit_len_reg) &&
      !out_busy_reg && !(hs_pend_reg && ready_more);

   wire take = rx_valid && rx_ready;
   wire is_inl = cfg_inl_cr ? (rx_data == `STP_CH_CR) :
      (rx_data == `STP_CH_NUL);
   wire is_erase = (rx_data == `STP_CH_BS) || (rx_data == `STP_CH_DEL);
   wire is_print = (rx_data >= `STP_PRINT_LO) &&
      (rx_data <= `STP_PRINT_HI);
   wire is_ctl_nl = (rx_data == `STP_CH_CR) || (rx_data == `STP_CH_LF) ||
      (rx_data == `STP_CH_NUL);

   // ---------------------------------------------------------------
   // parser state
   // ---------------------------------------------------------------
   reg do_submit;
   reg do_erase;
   reg do_nl;
   reg do_clear;
   always @*
   begin
      st_next = st_reg;
      len_next = len_reg;
      do_submit = 1'b0;
      do_erase = 1'b0;
      do_nl = 1'b0;
      do_clear = 1'b0;
      if (take)
      begin
         case (st_reg)
            S_HUNT:
            begin
               if (rx_data == `STP_CH_LBR)
               begin
                  st_next = S_BODY;
                  len_next = 7'h01;
               end
            end
            S_BODY, S_CONT:
            begin
               if (rx_data == `STP_CH_ESC)
               begin
                  st_next = S_ESC;
                  do_clear = 1'b1;
               end
               else if (st_reg == S_CONT && is_inl)
                  st_next = S_BODY;
               else if (is_erase && cfg_edit_en)
               begin
                  do_erase = 1'b1;
                  st_next = S_BODY;
                  if (len_reg > 7'h01)
                     len_next = len_reg - 7'h01;
               end
               else if (rx_data == `STP_CH_RBR)
               begin
                  if (len_reg >= MAXLEN)
                  begin
                     st_next = S_HUNT;
                     do_clear = 1'b1;
                  end
                  else
                  begin
                     do_submit = 1'b1;
                     st_next = S_HUNT;
                     len_next = len_reg + 7'h01;
                  end
               end
               else if (is_print && len_reg < MAXLEN - 1)
               begin
                  st_next = (rx_data == `STP_CH_BSL) ? S_CONT : S_BODY;
                  // held backslash and this character both stored
                  if (st_reg == S_CONT && rx_data != `STP_CH_BSL)
                     len_next = len_reg + 7'h02;
                  else if (st_reg == S_CONT || rx_data != `STP_CH_BSL)
                     len_next = len_reg + 7'h01;
               end
               else if (is_ctl_nl && !is_inl)
                  st_next = st_reg;
               else
               begin
                  st_next = S_HUNT;
                  do_clear = 1'b1;
               end
            end
            S_ESC:
            begin
               if (is_inl && cfg_edit_en)
                  do_nl = 1'b1;
               st_next = (rx_data == `STP_CH_LBR) ? S_BODY : S_HUNT;
               len_next = (rx_data == `STP_CH_LBR) ? 7'h01 : 7'h00;
            end
            default: st_next = S_HUNT;
         endcase
      end
   end

   // a held backslash becomes data when a printable character other than ']' follows it
   always @(posedge mclk or negedge rst_sn)
   begin
      if (!rst_sn)
      begin
         st_reg <= S_HUNT;
         len_reg <= 7'h00;
      end
      else
      begin
         st_reg <= st_next;
         len_reg <= do_clear ? 7'h00 : len_next;
      end
   end

   always @(posedge mclk)
   begin
      if (take && st_reg == S_HUNT && rx_data == `STP_CH_LBR)
         buf_reg[0] <= rx_data;
      else if (take && st_reg == S_ESC)
         buf_reg[0] <= rx_data;
      else if (take && st_reg == S_CONT && !is_inl && len_next > len_reg)
      begin
         buf_reg[len_reg] <= `STP_CH_BSL;
         buf_reg[len_reg + 7'h01] <= rx_data;
      end
      else if (take && len_next > len_reg)
         buf_reg[len_reg] <= rx_data;
   end

   // ---------------------------------------------------------------
   // line hand-out and classification
   // ---------------------------------------------------------------
   wire sys_pre = (buf_reg[1] == `STP_CH_S) && (buf_reg[2] == `STP_CH_Y) &&
      (buf_reg[3] == `STP_CH_S);

   function [3:0] hexval;
      input [7:0] c;
      begin
         if (c >= 8'h30 && c <= 8'h39)
            hexval = c[3:0];
         else if ((c | 8'h20) >= 8'h61 && (c | 8'h20) <= 8'h66)
            hexval = c[3:0] + 4'h9;
         else
            hexval = 4'h0;
      end
   endfunction

   reg [3:0] hi_reg;
   reg half_reg;
   reg [1:0] hexcnt_reg;
   wire [7:0] cur = buf_reg[out_idx_reg];
   wire cur_hex = (cur >= 8'h30 && cur <= 8'h39) ||
      ((cur | 8'h20) >= 8'h61 && (cur | 8'h20) <= 8'h66);

   always @(posedge mclk or negedge rst_sn)
   begin
      if (!rst_sn)
      begin
         out_busy_reg <= 1'b0;
         out_idx_reg <= 7'h00;
         msg_byte <= 8'h00;
         msg_byte_valid <= 1'b0;
         msg_done <= 1'b0;
         msg_is_text <= 1'b0;
         msg_is_bridged <= 1'b0;
         msg_error <= 1'b0;
         msg_len <= 7'h00;
         hi_reg <= 4'h0;
         half_reg <= 1'b0;
         hexcnt_reg <= 2'h0;
      end
      else
      begin
         msg_byte_valid <= 1'b0;
         msg_done <= 1'b0;
         if (do_submit)
         begin
            out_busy_reg <= 1'b1;
            out_idx_reg <= 7'h01;
            msg_len <= len_next;
            msg_is_text <= sys_pre;
            msg_is_bridged <= 1'b0;
            msg_error <= 1'b0;
            half_reg <= 1'b0;
            hexcnt_reg <= 2'h0;
         end
         else if (out_busy_reg)
         begin
            out_idx_reg <= out_idx_reg + 7'h01;
            if (out_idx_reg >= msg_len - 7'h01)
            begin
               out_busy_reg <= 1'b0;
               msg_done <= 1'b1;
               // gate before a session is left to the command layer
               if (!session_up && !msg_is_text)
                  msg_error <= msg_error;
               if (half_reg)
                  msg_error <= 1'b1;
            end
            else if (msg_is_text)
            begin
               msg_byte <= cur;
               msg_byte_valid <= 1'b1;
            end
            else if (cur == `STP_CH_SP && !half_reg)
               msg_error <= msg_error;
            else if (cur_hex)
            begin
               half_reg <= !half_reg;
               hi_reg <= hexval(cur);
               if (half_reg)
               begin
                  msg_byte <= {hi_reg, hexval(cur)};
                  msg_byte_valid <= 1'b1;
                  if (hexcnt_reg != 2'h3)
                     hexcnt_reg <= hexcnt_reg + 2'h1;
                  if (hexcnt_reg == 2'h1)
                     msg_is_bridged <= ({hi_reg, hexval(cur)} & 8'h03) !=
                        {6'h00, `STP_BRIDGE_NONE};
               end
            end
            else
               msg_error <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // transmit sequencing: echo, erase, newline, handshake
   // ---------------------------------------------------------------
   integer k;
   reg [2:0] nl_n;
   reg [7:0] nl0;
   reg [7:0] nl1;
   always @*
   begin
      nl0 = `STP_CH_CR;
      nl1 = `STP_CH_LF;
      case (cfg_onl_sel)
         `STP_ONL_CRLF: nl_n = 3'h2;
         `STP_ONL_NUL: begin nl_n = 3'h1; nl0 = `STP_CH_NUL; end
         `STP_ONL_CR: nl_n = 3'h1;
         `STP_ONL_LFCR:
         begin
            nl_n = 3'h2;
            nl0 = `STP_CH_LF;
            nl1 = `STP_CH_CR;
         end
         `STP_ONL_LF: begin nl_n = 3'h1; nl0 = `STP_CH_LF; end
         default: nl_n = 3'h0;
      endcase
   end

   always @(posedge mclk or negedge rst_sn)
   begin
      if (!rst_sn)
      begin
         emit_reg <= 3'h0;
         emit_len_reg <= 3'h0;
         hs_pend_reg <= 1'b0;
         for (k = 0; k < 7; k = k + 1)
            emit_buf_reg[k] <= 8'h00;
      end
      else
      begin
         if (emit_reg != emit_len_reg)
         begin
            if (q_space)
               emit_reg <= emit_reg + 3'h1;
         end
         else if (hs_pend_reg && ready_more && !out_busy_reg)
         begin
            hs_pend_reg <= 1'b0;
            emit_buf_reg[0] <= `STP_CH_LBR;
            emit_buf_reg[1] <= `STP_CH_S;
            emit_buf_reg[2] <= `STP_CH_Y;
            emit_buf_reg[3] <= `STP_CH_S;
            emit_buf_reg[4] <= `STP_CH_RBR;
            emit_buf_reg[5] <= nl0;
            emit_buf_reg[6] <= nl1;
            emit_reg <= 3'h0;
            emit_len_reg <= 3'h5 + nl_n;
         end
         else if (do_erase)
         begin
            emit_buf_reg[0] <= cfg_erase_bksp ? `STP_CH_BS : `STP_CH_DEL;
            emit_buf_reg[1] <= `STP_CH_SP;
            emit_buf_reg[2] <= `STP_CH_BS;
            emit_reg <= 3'h0;
            emit_len_reg <= cfg_erase_bksp ? 3'h3 : 3'h1;
         end
         else if (do_nl)
         begin
            emit_buf_reg[0] <= nl0;
            emit_buf_reg[1] <= nl1;
            emit_reg <= 3'h0;
            emit_len_reg <= nl_n;
         end
         else
         begin
            emit_reg <= 3'h0;
            emit_len_reg <= 3'h0;
         end
         // a new line's request wins over the clear above
         if (do_submit && cfg_hshk_en)
            hs_pend_reg <= 1'b1;
      end
   end

   always @*
   begin
      q_push = 1'b0;
      q_data = rx_data;
      if (take && cfg_echo_en && !(do_erase))
         q_push = 1'b1;
      else if (emit_reg != emit_len_reg && q_space)
      begin
         q_push = 1'b1;
         q_data = emit_buf_reg[emit_reg];
      end
   end

   stp_txq #(
      .DEPTH(QDEPTH),
      .AW($clog2(QDEPTH))
   ) u_txq (
      .mclk(mclk),
      .rst_n(rst_sn),
      .push(q_push),
      .push_data(q_data),
      .space4(q_space),
      .empty(),
      .tx_data(tx_data),
      .tx_valid(tx_valid),
      .tx_ready(tx_ready)
   );
endmodule

`default_nettype wire

// ==== logic/stp_txq.v ====
/*
 Small ordered byte queue in front of the serial transmitter.
 Assumes the transmitter takes a byte when tx_valid and tx_ready are high.
*/
`timescale 1ns/1ps
`default_nettype none

module stp_txq #(
   parameter DEPTH = 16,
   parameter AW = 4
)(
   input wire mclk,
   input wire rst_n,
   input wire push,
   input wire [7:0] push_data,
   output wire space4,
   output wire empty,
   output wire [7:0] tx_data,
   output wire tx_valid,
   input wire tx_ready
);
   reg [7:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   wire pop;

   assign pop = tx_valid && tx_ready;
   assign empty = (cnt_reg == {(AW+1){1'b0}});
   assign tx_valid = !empty;
   assign tx_data = mem_reg[rd_reg];
   assign space4 = (cnt_reg <= DEPTH - 4);

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_reg <= wr_reg + 1'b1;
         if (pop)
            rd_reg <= rd_reg + 1'b1;
         if (push && !pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end

   always @(posedge mclk)
   begin
      if (push)
         mem_reg[wr_reg] <= push_data;
   end
endmodule

`default_nettype wire

// ==== testbench/stp_console_model.sv ====
/*
 Remote console model: offers bytes to the parser, collects its output.
 Assumes the parser's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module stp_console_model (
   input wire logic mclk,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [7:0] got[$];
   logic slow;
   logic hung;
   initial
   begin
      rx_data = 8'hFF;
      rx_valid = 1'b0;
      tx_ready = 1'b1;
      slow = 1'b0;
      hung = 1'b0;
   end
   // stalls every other cycle when slow
   always @(posedge mclk)
   begin
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
      tx_ready <= #1 slow ? ~tx_ready : 1'b1;
   end
   task put(input logic [7:0] b);
      integer n;
      n = 0;
      @(posedge mclk);
      #1;
      rx_data = b;
      rx_valid = 1'b1;
      // ready settles by the falling edge; the next rising edge takes
      @(negedge mclk);
      while (!rx_ready && n < 500)
      begin
         n = n + 1;
         @(negedge mclk);
      end
      if (n == 500)
         hung = 1'b1;
      @(posedge mclk);
      #1;
      rx_valid = 1'b0;
      rx_data = ~b;
   endtask
endmodule
`default_nettype wire

// ==== testbench/stp_parser_sva.sv ====
/*
 Port checker for the terminal line parser.
 Assumes binding to stp_parser, one clock, active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module stp_parser_chk #(
   parameter MAXLEN = 122
)(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic cfg_echo_en,
   input wire logic cfg_hshk_en,
   input wire logic ready_more,
   input wire logic msg_byte_valid,
   input wire logic msg_done,
   input wire logic msg_is_text,
   input wire logic msg_is_bridged,
   input wire logic [7:0] msg_swid,
   input wire logic [1:0] msg_lun,
   input wire logic [6:0] msg_len
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   sequence s_acc(logic [7:0] b);
      tx_valid && tx_ready && tx_data == b;
   endsequence
   sequence s_sys_tail;
      ##[1:4] s_acc(8'h53) ##[1:4] s_acc(8'h59)
      ##[1:4] s_acc(8'h53) ##[1:4] s_acc(8'h5D);
   endsequence
   chk_tx_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx byte changed before taken");
   chk_echo_push: assert property (
      rx_valid && rx_ready && cfg_echo_en |=> tx_valid)
      else $error("no echo byte queued");
   chk_hshk_start: assert property (
      msg_done && msg_is_text && cfg_hshk_en && ready_more && !cfg_echo_en
      |-> ##[1:300] s_acc(8'h5B) or ##[1:300] (tx_valid && tx_data == 8'h5B))
      else $error("handshake missing");
   chk_hshk_order: assert property (
      (!cfg_echo_en and s_acc(8'h5B)) |-> s_sys_tail)
      else $error("handshake text wrong");
   chk_out_refuse: assert property (
      msg_byte_valid |-> !rx_ready)
      else $error("rx open during hand-out");
   chk_done_pulse: assert property (
      msg_done |=> !msg_done)
      else $error("line end not a pulse");
   chk_done_after: assert property (
      msg_byte_valid |-> ##[0:130] msg_done)
      else $error("line end missing");
   chk_text_nobrg: assert property (
      msg_done && msg_is_text |-> !msg_is_bridged)
      else $error("text line flagged bridged");
   chk_len_limit: assert property (
      msg_done |-> msg_len <= MAXLEN)
      else $error("line longer than limit");
   chk_swid_fixed: assert property (
      msg_swid == 8'h47 && msg_lun == 2'h0)
      else $error("implied id wrong");
endmodule
bind stp_parser stp_parser_chk #(.MAXLEN(MAXLEN)) u_chk (
   .mclk(mclk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .cfg_echo_en(cfg_echo_en), .cfg_hshk_en(cfg_hshk_en),
   .ready_more(ready_more), .msg_byte_valid(msg_byte_valid),
   .msg_done(msg_done), .msg_is_text(msg_is_text),
   .msg_is_bridged(msg_is_bridged), .msg_swid(msg_swid),
   .msg_lun(msg_lun), .msg_len(msg_len)
);
`default_nettype wire

// ==== testbench/testbench.sv ====
/*
 Self-checking bench for the terminal line parser.
 Assumes the console model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef logic [7:0] stp_bq[$];
   logic mclk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready;
   logic [7:0] rx_data, tx_data, msg_byte, msg_swid;
   logic cfg_edit_en, cfg_echo_en, cfg_hshk_en, cfg_erase_bksp, cfg_inl_cr;
   logic [2:0] cfg_onl_sel;
   logic session_up, ready_more, msg_byte_valid, msg_done, msg_is_text;
   logic msg_is_bridged, msg_error;
   logic [1:0] msg_lun;
   logic [6:0] msg_len;
   logic l_text, l_brg, l_err;
   integer failures, check_count, dn, seed;
   stp_bq mb;
   stp_parser dut (.mclk(mclk), .rst_n(rst_n), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .cfg_edit_en(cfg_edit_en),
      .cfg_echo_en(cfg_echo_en), .cfg_hshk_en(cfg_hshk_en),
      .cfg_erase_bksp(cfg_erase_bksp), .cfg_inl_cr(cfg_inl_cr),
      .cfg_onl_sel(cfg_onl_sel), .session_up(session_up),
      .ready_more(ready_more), .msg_byte(msg_byte),
      .msg_byte_valid(msg_byte_valid), .msg_done(msg_done),
      .msg_is_text(msg_is_text), .msg_is_bridged(msg_is_bridged),
      .msg_error(msg_error), .msg_swid(msg_swid), .msg_lun(msg_lun),
      .msg_len(msg_len));
   stp_console_model console (.mclk(mclk), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready));
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      if (msg_byte_valid === 1'b1)
         mb.push_back(msg_byte);
      if (msg_done === 1'b1)
      begin
         dn = dn + 1;
         l_text = msg_is_text;
         l_brg = msg_is_bridged;
         l_err = msg_error;
      end
   end
   // '~' stands for the null character
   function automatic stp_bq sq(input string s);
      stp_bq r;
      for (int i = 0; i < s.len(); i++)
         r.push_back(s[i] == "~" ? 8'h00 : s[i]);
      return r;
   endfunction
   function automatic string nl(input logic [2:0] sel);
      case (sel)
         3'h1: return "\r\n";
         3'h2: return "~";
         3'h3: return "\r";
         3'h4: return "\n\r";
         3'h5: return "\n";
         default: return "";
      endcase
   endfunction
   function automatic string tm();
      return cfg_inl_cr ? "\r" : "~";
   endfunction
   function automatic string hs();
      return {"[SYS]", nl(cfg_onl_sel)};
   endfunction
   function automatic string hx(input logic [7:0] b, input logic up);
      string t;
      t = $sformatf("%h", b);
      return up ? t.toupper() : t;
   endfunction
   task close_out;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      check_count = check_count + 1;
      if (seen !== ex)
      begin
         failures = failures + 1;
         $display("Error %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic cmpq(input string nm, input stp_bq q, input stp_bq e);
      check({nm, " count"}, q.size(), e.size());
      for (int i = 0; i < e.size() && i < q.size(); i++)
         check(nm, q[i], e[i]);
   endtask
   // one line in, then wait for both sides to fall quiet
   task automatic run(input string s, input stp_bq em, input stp_bq et,
                      input integer ed);
      integer n, idle, d0;
      stp_bq b;
      mb.delete();
      console.got.delete();
      d0 = dn;
      b = sq(s);
      foreach (b[i]) console.put(b[i]);
      n = 0;
      idle = 0;
      while (idle < 8 && n < 800)
      begin
         @(posedge mclk);
         n = n + 1;
         idle = (tx_valid === 1'b0 && rx_ready === 1'b1) ? idle + 1 : 0;
      end
      if (n == 800 || console.hung)
      begin
         failures = failures + 1;
         close_out();
      end
      else
      begin
         cmpq("msg bytes", mb, em);
         cmpq("tx bytes", console.got, et);
         check("lines", dn - d0, ed);
         #1;
      end
   endtask
   initial
   begin
      string s;
      logic [7:0] b;
      integer n;
      stp_bq e;
      failures = 0;
      check_count = 0;
      dn = 0;
      seed = 32'hB503;
      rst_n = 1'b0;
      cfg_edit_en = 1'b1;
      cfg_echo_en = 1'b0;
      cfg_hshk_en = 1'b1;
      cfg_erase_bksp = 1'b1;
      cfg_inl_cr = 1'b1;
      cfg_onl_sel = 3'h1;
      session_up = 1'b0;
      ready_more = 1'b1;
      repeat (16) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      for (int k = 0; k < 6; k++)
      begin
         cfg_onl_sel = k[2:0];
         run({"x]", "[SYS TMODE]", tm()}, sq("SYS TMODE"), sq(hs()),
             1);
         check("text", l_text, 1'b1);
      end
      cfg_onl_sel = 3'h1;
      for (int k = 0; k < 20; k++)
      begin
         n = 3 + {$random(seed)} % 6;
         s = "[";
         e.delete();
         for (int j = 0; j < n; j++)
         begin
            b = $random(seed);
            s = {s, (j > 0 && b[2]) ? string'(" ") : string'(""),
                 hx(b, b[3])};
            e.push_back(b);
         end
         session_up = b[4];
         run({s, "]", tm()}, e, sq(hs()), 1);
         check("bridged", l_brg, e[1][1:0] != 2'h0);
         check("text", l_text, 1'b0);
         check("error", l_err, 1'b0);
      end
      for (int k = 0; k < 4; k++)
      begin
         cfg_erase_bksp = k[0];
         run({"[SYS TX", k[1] ? "\177" : "\010", "MODE]", tm()},
             sq("SYS TMODE"),
             sq({k[0] ? string'("\010 \010") : string'("\177"),
                 hs()}), 1);
      end
      for (int k = 0; k < 2; k++)
      begin
         cfg_inl_cr = k[0];
         run({"[SYS \\", tm(), "TMODE]", tm()}, sq("SYS TMODE"),
             sq(hs()), 1);
      end
      run({"[SYS A\001[SYS TMODE]", tm()}, sq("SYS TMODE"),
          sq(hs()), 1);
      run({"[SYS A\033[SYS TMODE]", tm()}, sq("SYS TMODE"),
          sq(hs()), 1);
      run({"[SYS A\033", tm(), "[SYS TMODE]", tm()}, sq("SYS TMODE"),
          sq({nl(cfg_onl_sel), hs()}), 1);
      cfg_edit_en = 1'b0;
      run({"[SYS A\010[SYS TMODE]", tm()}, sq("SYS TMODE"),
          sq(hs()), 1);
      s = {"SYS", {117{"A"}}};
      run({"[", s, "]", tm()}, sq(s), sq(hs()), 1);
      run({"[", s, "A]", tm()}, sq(""), sq(""), 0);
      cfg_echo_en = 1'b1;
      cfg_hshk_en = 1'b0;
      console.slow = 1'b1;
      s = {"[SYS TMODE]", tm()};
      run(s, sq("SYS TMODE"), sq(s), 1);
      close_out();
   end
endmodule
`default_nettype wire
